//--- bsm_defs.svh
// Offsets, field positions, reset values and timing counts of the bridge stream block.
// Assumes nothing; included by bare name.
`ifndef BSM_DEFS_SVH
`define BSM_DEFS_SVH
`define BSM_A_CONFIG 8'h00
`define BSM_A_STATUS 8'h04
`define BSM_A_OFFSET 8'h08
`define BSM_A_GAIN 8'h0C
`define BSM_A_READING 8'h10
`define BSM_CFG_LF 0
`define BSM_CFG_DLY 1
`define BSM_CFG_EXC5 2
`define BSM_CFG_DLY_LO 16
`define BSM_CFG_RST 32'h00000000
`define BSM_GAIN_RST 24'sh004000
`define BSM_GAIN_FRAC 14
`define BSM_NOM10_MV 16'h2710
`define BSM_NOM5_MV 16'h1388
`define BSM_MAG_MAX 24'h98967F
`define BSM_CLK_NS 40
`define BSM_TICK_NS 1000
`define BSM_TICK_CYC 8'((`BSM_TICK_NS + `BSM_CLK_NS - 1) / `BSM_CLK_NS)
`define BSM_LAST_READ 4'hA
`define BSM_LAST_SHORT 4'h1
`define BSM_CH_STAR 8'h2A
`define BSM_CH_QUES 8'h3F
`define BSM_CH_CR 8'h0D
`define BSM_CH_LF 8'h0A
`define BSM_CH_PLUS 8'h2B
`define BSM_CH_MINUS 8'h2D
`define BSM_CH_DOT 8'h2E
`define BSM_CH_ZERO 8'h30
`define BSM_CH_NINE 8'h39
`define BSM_CH_DOLLAR 8'h24
`define BSM_CH_A 8'h41
`define BSM_CH_Z 8'h5A
`define BSM_CH_W 8'h57
`define BSM_CH_E 8'h45
`define BSM_CH_T 8'h54
`define BSM_CH_S 8'h53
`define BSM_CH_R 8'h52
`define BSM_CH_D 8'h44
`endif

//--- bsm_pkg.sv
// Types shared by the bridge stream block.
// Assumes nothing of its surroundings.
package bsm_pkg;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } bsm_byte_t;
  typedef enum logic [1:0] {K_READ, K_ACK, K_NAK} bsm_kind_t;
  typedef enum logic [1:0] {S_IDLE, S_SEND, S_WAIT} bsm_state_t;
endpackage

//--- bsm_top.sv
// Bridge module digital side: streaming, trims, ratiometric scaling, AHB-Lite registers.
// Assumes one clock, a byte-wide serial side and an ADC that pulses adc_valid.
`timescale 1ns/1ns
`default_nettype none
`include "bsm_defs.svh"
module bsm_top (
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic [31:0]            hrdata,
  output logic                   hresp,
  input  wire logic              continuous_select_n,
  input  wire logic              adc_valid,
  input  wire logic [23:0]       adc_raw,
  input  wire logic [15:0]       exc_mv,
  input  wire bsm_pkg::bsm_byte_t rx_byte,
  input  wire logic              tx_ready,
  output bsm_pkg::bsm_byte_t     tx_byte
);
  logic [31:0]         cfg;
  logic signed [23:0]  off;
  logic signed [23:0]  gain;
  logic signed [23:0]  raw_q;
  logic [15:0]         exc_q;
  logic                stream_q;
  logic                pend_q;
  logic                resp_pend;
  logic                we_armed;
  logic                cr_go;
  logic                lf_q;
  bsm_pkg::bsm_state_t state;
  bsm_pkg::bsm_kind_t  kind;
  bsm_pkg::bsm_kind_t  rkind;
  logic [3:0]          idx;
  logic signed [23:0]  msg_val;
  logic [15:0]         dly;
  logic [7:0]          tick;
  logic [7:0]          c0;
  logic [7:0]          c1;
  logic                neg;
  logic [23:0]         acc;
  logic                wr_pend;
  logic [7:0]          a_q;
  logic [31:0]         rd_mux;
  logic [15:0]         nom;
  logic signed [31:0]  ratio;
  logic signed [23:0]  reading;
  logic signed [23:0]  target;
  logic signed [23:0]  next_gain;
  logic                is_we;
  logic                is_tz;
  logic                is_ts;
  logic                is_rd;
  logic [23:0]         wait_cyc;

  // ----------------------------------------
  // Arithmetic
  // ----------------------------------------
  // Ratiometric step: raw times nominal over measured excitation.
  function automatic logic signed [31:0] ratio_f(input logic signed [23:0] r,
                                                 input logic [15:0] e, input logic [15:0] n);
    logic signed [47:0] p;
    p = r * $signed({1'b0, n});
    if (e != 16'h0000) begin
      p = p / $signed({1'b0, e});
    end
    return p[31:0];
  endfunction

  // Gain in Q14, then offset; wraps on purpose beyond 24 bits.
  function automatic logic signed [23:0] scale_f(input logic signed [31:0] r,
                                                 input logic signed [23:0] g, input logic signed [23:0] o);
    logic signed [63:0] p;
    p = r * g;
    p = p >>> `BSM_GAIN_FRAC;
    return $signed(p[23:0]) + o;
  endfunction

  // Last character index of a message.
  function automatic logic [3:0] last_f(input bsm_pkg::bsm_kind_t k, input logic lf);
    return ((k == bsm_pkg::K_READ) ? `BSM_LAST_READ : `BSM_LAST_SHORT) + {3'h0, lf};
  endfunction

  // Character at an index; magnitude is clamped to the seven printable digits.
  function automatic logic [7:0] char_f(input bsm_pkg::bsm_kind_t k, input logic [3:0] i,
                                        input logic signed [23:0] v);
    logic [23:0] t;
    logic [3:0]  pos;
    t = v[23] ? 24'(-v) : 24'(v);
    if (t > `BSM_MAG_MAX) begin
      t = `BSM_MAG_MAX;
    end
    pos = (i > 4'h7) ? 4'(4'h9 - i) : 4'(4'h8 - i);
    for (int n = 0; n < 7; n++) begin
      if (4'(n) < pos) begin
        t = t / 24'h00000A;
      end
    end
    if (k != bsm_pkg::K_READ) begin
      if (i == 4'h0) begin
        return (k == bsm_pkg::K_ACK) ? `BSM_CH_STAR : `BSM_CH_QUES;
      end
      return (i == 4'h1) ? `BSM_CH_CR : `BSM_CH_LF;
    end
    if (i == 4'h0) begin
      return `BSM_CH_STAR;
    end else if (i == 4'h1) begin
      return v[23] ? `BSM_CH_MINUS : `BSM_CH_PLUS;
    end else if (i == 4'h7) begin
      return `BSM_CH_DOT;
    end else if (i == 4'hA) begin
      return `BSM_CH_CR;
    end else if (i == 4'hB) begin
      return `BSM_CH_LF;
    end
    return `BSM_CH_ZERO + 8'(t % 24'h00000A);
  endfunction

  // Present reading in 10 uV digits and trim targets.
  assign nom = cfg[`BSM_CFG_EXC5] ? `BSM_NOM5_MV : `BSM_NOM10_MV;
  assign ratio = ratio_f(raw_q, exc_q, nom);
  assign reading = scale_f(ratio, gain, off);
  assign target = neg ? 24'(-$signed(acc)) : $signed(acc);
  assign is_we = (c0 == `BSM_CH_W) && (c1 == `BSM_CH_E);
  assign is_tz = (c0 == `BSM_CH_T) && (c1 == `BSM_CH_Z);
  assign is_ts = (c0 == `BSM_CH_T) && (c1 == `BSM_CH_S);
  assign is_rd = (c0 == `BSM_CH_R) && (c1 == `BSM_CH_D);

  // Span gain so the present ratio reads the target after the offset.
  always_comb begin
    logic signed [47:0] q;
    q = 48'(target - off) <<< `BSM_GAIN_FRAC;
    next_gain = gain;
    if (ratio != 32'sh00000000) begin
      q = q / ratio;
      next_gain = q[23:0];
    end
  end

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  // Read data is loaded at the end of the address phase, so no wait states.
  always_comb begin
    rd_mux = 32'h00000000;
    if (haddr[7:0] == `BSM_A_CONFIG) begin
      rd_mux = cfg;
    end else if (haddr[7:0] == `BSM_A_STATUS) begin
      rd_mux = {29'h00000000, state != bsm_pkg::S_IDLE, we_armed, stream_q};
    end else if (haddr[7:0] == `BSM_A_OFFSET) begin
      rd_mux = 32'(off);
    end else if (haddr[7:0] == `BSM_A_GAIN) begin
      rd_mux = 32'(gain);
    end else if (haddr[7:0] == `BSM_A_READING) begin
      rd_mux = 32'(reading);
    end
  end

  // Bus phases; hsize is ignored since only whole words are defined.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      wr_pend <= 1'b0;
      a_q <= 8'h00;
      cfg <= `BSM_CFG_RST;
    end else if (clk_en) begin
      wr_pend <= hsel && hready && htrans[1] && hwrite;
      if (hsel && hready && htrans[1]) begin
        a_q <= haddr[7:0];
        hrdata <= hwrite ? 32'h00000000 : rd_mux;
      end
      if (wr_pend && (a_q == `BSM_A_CONFIG)) begin
        cfg <= hwdata;
      end
    end
  end

  // ----------------------------------------
  // Command receive and trims
  // ----------------------------------------
  // Parser keeps the last two letters, a sign and the digits up to CR.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      c0 <= 8'h00;
      c1 <= 8'h00;
      neg <= 1'b0;
      acc <= 24'h000000;
      cr_go <= 1'b0;
    end else if (clk_en) begin
      cr_go <= 1'b0;
      if (stream_q || (rx_byte.valid && rx_byte.data == `BSM_CH_DOLLAR)) begin
        c0 <= 8'h00;
        c1 <= 8'h00;
        neg <= 1'b0;
        acc <= 24'h000000;
      end else if (rx_byte.valid) begin
        if (rx_byte.data >= `BSM_CH_A && rx_byte.data <= `BSM_CH_Z) begin
          c0 <= c1;
          c1 <= rx_byte.data;
          acc <= 24'h000000;
          neg <= 1'b0;
        end else if (rx_byte.data == `BSM_CH_MINUS) begin
          neg <= 1'b1;
        end else if (rx_byte.data >= `BSM_CH_ZERO && rx_byte.data <= `BSM_CH_NINE) begin
          acc <= 24'(acc * 24'h00000A) + {16'h0000, 8'(rx_byte.data - `BSM_CH_ZERO)};
        end else if (rx_byte.data == `BSM_CH_CR) begin
          cr_go <= 1'b1;
        end
      end
    end
  end

  // Trims execute on CR; write enable is good for the very next command only.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      we_armed <= 1'b0;
      off <= 24'sh000000;
      gain <= `BSM_GAIN_RST;
    end else if (clk_en && cr_go) begin
      we_armed <= is_we;
      if (is_tz && we_armed) begin
        off <= target - scale_f(ratio, gain, 24'sh000000);
      end
      if (is_ts && we_armed) begin
        gain <= next_gain;
      end
    end
  end

  // A completed command requests a reply; the set wins over the clear.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      resp_pend <= 1'b0;
      rkind <= bsm_pkg::K_NAK;
    end else if (clk_en) begin
      if (cr_go) begin
        resp_pend <= 1'b1;
        rkind <= is_rd ? bsm_pkg::K_READ : ((is_we || ((is_tz || is_ts) && we_armed)) ?
                 bsm_pkg::K_ACK : bsm_pkg::K_NAK);
      end else if (state == bsm_pkg::S_IDLE && !stream_q) begin
        resp_pend <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Samples and transmit
  // ----------------------------------------
  // Latest conversion; in stream mode each one marks a streamed send as owed.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      raw_q <= 24'sh000000;
      exc_q <= 16'h0000;
      pend_q <= 1'b0;
    end else if (clk_en) begin
      if (adc_valid) begin
        raw_q <= adc_raw;
        exc_q <= exc_mv;
      end
      if (adc_valid && stream_q) begin
        pend_q <= 1'b1;
      end else if (state == bsm_pkg::S_IDLE && stream_q) begin
        pend_q <= 1'b0;
      end
    end
  end

  // Message engine; mode is resampled only while idle so no message is cut.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state <= bsm_pkg::S_IDLE;
      stream_q <= 1'b0;
      kind <= bsm_pkg::K_ACK;
      idx <= 4'h0;
      msg_val <= 24'sh000000;
      lf_q <= 1'b0;
      dly <= 16'h0000;
      tick <= 8'h00;
      tx_byte <= '0;
    end else if (clk_en) begin
      case (state)
        bsm_pkg::S_IDLE: begin
          stream_q <= !continuous_select_n;
          idx <= 4'h0;
          lf_q <= cfg[`BSM_CFG_LF];
          msg_val <= reading;
          if (stream_q && pend_q) begin
            state <= bsm_pkg::S_SEND;
            kind <= bsm_pkg::K_READ;
            tx_byte <= {1'b1, char_f(bsm_pkg::K_READ, 4'h0, reading)};
          end else if (!stream_q && resp_pend) begin
            state <= bsm_pkg::S_SEND;
            kind <= rkind;
            tx_byte <= {1'b1, char_f(rkind, 4'h0, reading)};
          end
        end
        bsm_pkg::S_SEND: begin
          if (tx_ready && idx == last_f(kind, lf_q)) begin
            tx_byte.valid <= 1'b0;
            state <= bsm_pkg::S_IDLE;
            dly <= cfg[31:`BSM_CFG_DLY_LO];
            tick <= 8'h00;
            if (stream_q && cfg[`BSM_CFG_DLY] && cfg[31:`BSM_CFG_DLY_LO] != 16'h0000) begin
              state <= bsm_pkg::S_WAIT;
            end
          end else if (tx_ready) begin
            idx <= idx + 4'h1;
            tx_byte.data <= char_f(kind, idx + 4'h1, msg_val);
          end
        end
        bsm_pkg::S_WAIT: begin
          tick <= tick + 8'h01;
          if (tick == `BSM_TICK_CYC - 8'h01) begin
            tick <= 8'h00;
            dly <= dly - 16'h0001;
            if (dly == 16'h0001) begin
              state <= bsm_pkg::S_IDLE;
            end
          end
        end
        default: begin
          state <= bsm_pkg::S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // A frozen clock enable disables each attempt.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n || !clk_en);
  property p_sel_idle;
    state == bsm_pkg::S_IDLE && continuous_select_n |=> !stream_q;
  endproperty
  a_sel_idle: assert property (p_sel_idle) else $error("select high did not leave stream mode");
  property p_no_unsolicited;
    !stream_q && state == bsm_pkg::S_IDLE && !resp_pend |=> state == bsm_pkg::S_IDLE;
  endproperty
  a_no_unsolicited: assert property (p_no_unsolicited) else $error("send without request");
  property p_stream_send;
    stream_q && pend_q && state == bsm_pkg::S_IDLE |=> state == bsm_pkg::S_SEND && kind == bsm_pkg::K_READ
      && tx_byte.valid && tx_byte.data == `BSM_CH_STAR;
  endproperty
  a_stream_send: assert property (p_stream_send) else $error("streamed reading not started");
  property p_sign_second;
    tx_byte.valid && tx_ready && kind == bsm_pkg::K_READ && idx == 4'h0 |=> tx_byte.data == `BSM_CH_PLUS
      || tx_byte.data == `BSM_CH_MINUS;
  endproperty
  a_sign_second: assert property (p_sign_second) else $error("sign missing after star");
  property p_lf;
    tx_byte.valid && tx_ready && tx_byte.data == `BSM_CH_CR |=> lf_q ? tx_byte.data == `BSM_CH_LF
      && tx_byte.valid : !tx_byte.valid;
  endproperty
  a_lf: assert property (p_lf) else $error("line feed option broken");
  property p_ignore;
    stream_q |=> !cr_go;
  endproperty
  a_ignore: assert property (p_ignore) else $error("command taken in stream mode");
  property p_tz_keeps_span;
    cr_go && is_tz |=> $stable(gain);
  endproperty
  a_tz_keeps_span: assert property (p_tz_keeps_span) else $error("zero trim moved gain");
  property p_protect;
    cr_go && !we_armed |=> $stable(off) && $stable(gain);
  endproperty
  a_protect: assert property (p_protect) else $error("trim without write enable");
  property p_mode_hold;
    state != bsm_pkg::S_IDLE |=> $stable(stream_q);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed mid message");
  // Cycles spent in the transmit delay, counted apart from the engine's own tick and delay counters.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wait_cyc <= 24'h000000;
    end else if (clk_en) begin
      wait_cyc <= (state == bsm_pkg::S_WAIT) ? wait_cyc + 24'h000001 : 24'h000000;
    end
  end
  property p_delay_len;
    state == bsm_pkg::S_WAIT ##1 state == bsm_pkg::S_IDLE |->
      wait_cyc == 24'(cfg[31:`BSM_CFG_DLY_LO]) * 24'(`BSM_TICK_CYC);
  endproperty
  a_delay_len: assert property (p_delay_len) else $error("transmit delay has the wrong length");
  c_stream: cover property (stream_q && state == bsm_pkg::S_SEND ##1 state == bsm_pkg::S_WAIT);
  c_tz: cover property (cr_go && is_tz && we_armed);
  c_ts: cover property (cr_go && is_ts && we_armed);
  c_nak: cover property (state == bsm_pkg::S_IDLE && resp_pend && rkind == bsm_pkg::K_NAK);
endmodule
`default_nettype wire

//--- bsm_host_model.sv
// Serial-side partner of the bridge stream block: a host or display panel.
// Assumes one clock shared with the block and byte-wide serial ports on both sides.
`timescale 1ns/1ns
`default_nettype none
module bsm_host_model (
  input  wire logic               clk_sys,
  input  wire logic               stall,
  input  wire bsm_pkg::bsm_byte_t tx_byte,
  output logic                    tx_ready,
  output bsm_pkg::bsm_byte_t      rx_byte
);
  // ----------------------------------------
  // Receive side
  // ----------------------------------------
  logic [7:0] got[$];
  logic       phase;

  initial begin
    tx_ready = 1'b1;
    rx_byte  = '0;
    phase    = 1'b0;
  end

  // This is the only listener on the line, so every byte seen is the block's own. 
  // Stall halves the accept rate, so the block must hold each byte until taken.
  always @(posedge clk_sys) begin
    if (tx_byte.valid === 1'b1 && tx_ready === 1'b1) begin
      got.push_back(tx_byte.data);
    end
    phase    <= ~phase;
    tx_ready <= ~stall | phase;
  end

  // ----------------------------------------
  // Transmit side
  // ----------------------------------------
  // Sends a command and its closing carriage return, one character per cycle.
  // When idle the data lines show the inverse of the last character, not a stale copy.
  task automatic send_cmd(input string s);
    byte c;
    for (int i = 0; i <= s.len(); i++) begin
      c = (i == s.len()) ? 8'h0D : s[i];
      @(posedge clk_sys);
      rx_byte <= '{valid: 1'b1, data: c};
    end
    @(posedge clk_sys);
    rx_byte <= '{valid: 1'b0, data: ~c};
  endtask
endmodule
`default_nettype wire

//--- tb_bridge_module_stream_and_trim.sv
// Self-checking bench of the bridge stream block: registers over AHB-Lite, commands, trims, streaming.
// Assumes the block's defines header, its package and the host partner model.
`timescale 1ns/1ns
`default_nettype none
`include "bsm_defs.svh"
module tb_bridge_module_stream_and_trim;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic               clk_sys, reset_n, clk_en, hsel, hwrite, hreadyout, hresp;
  logic               continuous_select_n, adc_valid, tx_ready, stall;
  logic [31:0]        haddr, hwdata, hrdata, r;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic [23:0]        adc_raw;
  logic [15:0]        exc_mv;
  bsm_pkg::bsm_byte_t rx_byte, tx_byte;
  int                 n_errors, tests_run;
  string              ack, nak;

  bsm_top dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .continuous_select_n(continuous_select_n),
    .adc_valid(adc_valid), .adc_raw(adc_raw), .exc_mv(exc_mv), .rx_byte(rx_byte), .tx_ready(tx_ready),
    .tx_byte(tx_byte));
  bsm_host_model host_u (.clk_sys(clk_sys), .stall(stall), .tx_byte(tx_byte), .tx_ready(tx_ready),
    .rx_byte(rx_byte));

  // The clock runs at 25 MHz.
  initial begin
    clk_sys = 1'b0;
    forever begin
      #20 clk_sys = ~clk_sys;
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic report_and_stop;
    $display("mismatches %0d, checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Bounded wait for hready; a hung bus ends the run as a failure.
  task automatic wait_ready;
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (hreadyout !== 1'b1 && k < 100);
    if (k >= 100) begin
      n_errors++;
      $display("unexpected at %0t: bus never became ready", $time);
      report_and_stop();
    end
  endtask

  // One single-word transfer: address phase, then data phase; read data is taken at the closing edge.
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    hsize  <= 3'h2;
    wait_ready();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    chk({31'h00000000, hresp}, 32'h00000000, "bus response");
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h00000000, r);
    chk(r, exp, "register read");
  endtask

  task automatic adc(input logic [23:0] raw, input logic [15:0] exc);
    @(posedge clk_sys);
    adc_valid <= 1'b1;
    adc_raw   <= raw;
    exc_mv    <= exc;
    @(posedge clk_sys);
    adc_valid <= 1'b0;
  endtask

  // Short-form reading: star, sign, five digits, point, two digits, carriage return.
  function automatic string fmt(input int v);
    int m;
    m = (v < 0) ? -v : v;
    return $sformatf("*%s%05d.%02d%c", (v < 0) ? "-" : "+", m / 100, m % 100, 8'h0D);
  endfunction

  // Waits for the expected bytes, then lingers so that any surplus output is caught too.
  task automatic expect_msg(input string s);
    int k;
    k = 0;
    while (host_u.got.size() < s.len() && k < 3000) begin
      @(posedge clk_sys);
      k++;
    end
    repeat (80) @(posedge clk_sys);
    chk(host_u.got.size(), s.len(), "message length");
    for (int i = 0; i < s.len() && i < host_u.got.size(); i++) begin
      chk(host_u.got[i], s[i], "message byte");
    end
    host_u.got.delete();
    if (k >= 3000) begin
      report_and_stop();
    end
  endtask

  task automatic cmd(input string s, input string exp);
    host_u.send_cmd(s);
    expect_msg(exp);
  endtask

  initial begin
    repeat (100000) @(posedge clk_sys);
    n_errors++;
    $display("unexpected at %0t: run limit reached", $time);
    report_and_stop();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    n_errors = 0;
    tests_run = 0;
    reset_n = 1'b0;
    clk_en = 1'b1;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    continuous_select_n = 1'b1;
    adc_valid = 1'b0;
    adc_raw = '0;
    exc_mv = 16'h2710;
    stall = 1'b0;
    ack = $sformatf("*%c", 8'h0D);
    nak = $sformatf("?%c", 8'h0D);
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    // Reset values, an unmapped place and a write to a read-only register.
    rd_chk(`BSM_A_CONFIG, 32'h00000000);
    ahb(1'b1, `BSM_A_GAIN, 32'h00001234, r);
    rd_chk(`BSM_A_GAIN, 32'h00004000);
    rd_chk(`BSM_A_OFFSET, 32'h00000000);
    rd_chk(8'h40, 32'h00000000);
    // Select open: conversions alone send nothing; a read command is answered.
    adc(24'h0004D2, 16'h2710);
    expect_msg("");
    cmd("$RD", fmt(1234));
    rd_chk(`BSM_A_READING, 32'h000004D2);
    // Excitation 9.9 V against 10 V nominal, then 4.954 V against 5 V nominal.
    adc(24'h001356, 16'h26AC);
    cmd("$RD", fmt(5000));
    ahb(1'b1, `BSM_A_CONFIG, 32'h00000004, r);
    adc(24'h00135A, 16'h135A);
    cmd("$RD", fmt(5000));
    // Trims without write enable are refused and change nothing.
    cmd("$TZ+00000.00", nak);
    rd_chk(`BSM_A_OFFSET, 32'h00000000);
    cmd("$WE", ack);
    rd_chk(`BSM_A_STATUS, 32'h00000002);
    cmd("$TZ+00000.00", ack);
    rd_chk(`BSM_A_OFFSET, 32'hFFFFEC78);
    cmd("$RD", fmt(0));
    cmd("$WE", ack);
    cmd("$TS+00100.00", ack);
    rd_chk(`BSM_A_GAIN, 32'h0000C000);
    cmd("$RD", fmt(10000));
    cmd("$WE", ack);
    cmd("$TZ+00000.00", ack);
    rd_chk(`BSM_A_GAIN, 32'h0000C000);
    rd_chk(`BSM_A_OFFSET, 32'hFFFFC568);
    adc(24'h000000, 16'h135A);
    cmd("$RD", fmt(-15000));
    // Streaming with line feed and a 2 us delay, against a stalling sink.
    ahb(1'b1, `BSM_A_CONFIG, 32'h00020007, r);
    stall <= 1'b1;
    continuous_select_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    ahb(1'b0, `BSM_A_STATUS, 32'h00000000, r);
    chk(r & 32'h00000001, 32'h00000001, "streaming flag");
    cmd("$RD", "");
    adc(24'h000000, 16'h135A);
    repeat (3) @(posedge clk_sys);
    adc(24'h000064, 16'h135A);
    expect_msg({fmt(-15000), "\n", fmt(-14700), "\n"});
    // Back to command mode: conversions are silent again and commands answered.
    continuous_select_n <= 1'b1;
    stall <= 1'b0;
    repeat (100) @(posedge clk_sys);
    adc(24'h000064, 16'h135A);
    expect_msg("");
    cmd("$RD", {fmt(-14700), "\n"});
    // A conversion while the clock enable is low must not reach the reading.
    clk_en <= 1'b0;
    adc(24'h000200, 16'h135A);
    clk_en <= 1'b1;
    rd_chk(`BSM_A_READING, 32'hFFFFC694);
    // A second reset in mid-run returns setup and trims to their reset values.
    reset_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd_chk(`BSM_A_CONFIG, 32'h00000000);
    rd_chk(`BSM_A_GAIN, 32'h00004000);
    rd_chk(`BSM_A_OFFSET, 32'h00000000);
    report_and_stop();
  end
endmodule
`default_nettype wire
